// >>> hw/serial_shift_pkg.sv
package serial_shift_pkg;

  // register map, byte addresses on the bus
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] DATA_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 4'h8;

  // status field positions
  localparam int STAT_START_BIT = 7;
  localparam int STAT_WRAP_BIT = 6;
  localparam int STAT_STOP_BIT = 5;
  localparam int STAT_MISMATCH_BIT = 4;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;

  // control field positions
  localparam int CTRL_STROBE_BIT = 1;
  localparam int CTRL_TOGGLE_BIT = 0;

  // reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WM_OFF = 2'b00,
    WM_THREE = 2'b01,
    WM_TWO = 2'b10,
    WM_TWO_HOLD = 2'b11
  } wire_mode_t;

  typedef enum logic [1:0] {
    CS_SOFT = 2'b00,
    CS_TIMER = 2'b01,
    CS_EXT_POS = 2'b10,
    CS_EXT_NEG = 2'b11
  } clk_src_t;

  typedef struct packed {
    logic start_irq_enable;
    logic wrap_irq_enable;
    wire_mode_t wire_mode_select;
    clk_src_t clock_source_select;
    logic soft_clock_strobe;
    logic clock_pin_toggle;
  } ctrl_t;

  typedef struct packed {
    logic start_seen_flag;
    logic count_wrap_flag;
    logic stop_seen_flag;
    logic drive_mismatch_bit;
    logic [CNT_W-1:0] bit_counter_value;
  } status_t;

endpackage : serial_shift_pkg

// >>> hw/pin_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser per pin, followed by an edge detector on the stable stage
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;
  logic [W-1:0] prev_q;
  logic [1:0] warm_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= '0;
      stable_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins;
      stable_q <= meta_q;
      prev_q <= stable_q;
    end
  end

  // edges stay masked until prev_q holds a real sample: the reset zeros would
  // otherwise fake a rising edge on a line that idles high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      warm_q <= '0;
    end else if (warm_q != 2'h3) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  assign level = stable_q;
  assign rise = (warm_q == 2'h3) ? (stable_q & ~prev_q) : '0;
  assign fall = (warm_q == 2'h3) ? (~stable_q & prev_q) : '0;

endmodule : pin_sync

// >>> hw/serial_shift_unit.sv
`timescale 1ns/100ps
// Notes on behaviour
// - preset count fifteen makes edge interrupt source
// - data register is the live shifter
// - software write beats a same-cycle shift
// - shift left once per selected clock
// - inputs feed shifter even when outputs off
// - serial output driven from latched bit seven
// - latch half-open on external, open otherwise
// - new top bit shows at once when open
// - start flag on start or clock edge
// - start interrupt needs flag and both enables
// - start flag clears by one, frees clock
// - start detection wakes from every sleep
// - wrap flag sets on fifteen to zero
// - wrap interrupt needs flag and both enables
// - wrap flag clears by one, frees clock
// - wrap interrupt wakes from idle only
// - stop flag on stop, never interrupts
// - mismatch bit compares top bit with pin
// - counter readable, writable, counts selected clocks
// - toggle strobe clocks counter when selected
// - wire mode changes outputs, hold and start/stop detection
// - mode zero disables outputs, hold, detector
// - clock select chooses shift and count sources
// - mode three holds clock after wrap
// - soft strobe shifts and counts, reads zero
// - toggle strobe inverts clock port, reads zero
module serial_shift_unit
  import serial_shift_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system side
  input wire logic timer0_overflow,
  input wire logic global_irq_enable,
  input wire logic sleep_is_idle,
  input wire logic data_pin_dir,
  input wire logic clock_pin_dir,
  input wire logic data_port_bit,
  output logic start_irq,
  output logic wrap_irq,
  output logic wake_any_sleep,
  output logic wake_idle_sleep,
  // pins
  input wire logic serial_in_pin,
  input wire logic serial_clock_pin,
  output logic data_out_o,
  output logic data_out_oe_n,
  output logic sda_o,
  output logic sda_oe_n,
  output logic scl_o,
  output logic scl_oe_n
);

  logic [1:0] pin_level, pin_rise, pin_fall;
  logic scl_s, sda_s, scl_edge;
  ctrl_t ctrl_q;
  status_t stat;
  logic [7:0] data_q, data_d;
  logic [CNT_W-1:0] cnt_q;
  logic start_q, wrap_q, stop_q, hold_armed_q;
  logic clk_port_q, out_latch_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic wr_fire, wr_data, wr_stat, wr_ctrl;
  ctrl_t wr_val;
  logic shift_tick, count_tick, latch_open, two_wire, scl_hold;

  pin_sync #(.W(2)) u_pins (
    .clk(clk),
    .nrst(nrst),
    .pins({serial_clock_pin, serial_in_pin}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  assign scl_s = pin_level[1];
  assign sda_s = pin_level[0];
  assign scl_edge = pin_rise[1] | pin_fall[1];

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == DATA_OFS) || (a == STATUS_OFS) || (a == CONTROL_OFS);
  endfunction : addr_mapped

  // ---------------- bus slave: write path ----------------
  // address and data may arrive in either order; both are parked until the write fires, and no new ones are taken while the response waits
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_data = wr_fire && w_lane_q && (aw_addr_q == DATA_OFS);
  assign wr_stat = wr_fire && w_lane_q && (aw_addr_q == STATUS_OFS);
  assign wr_ctrl = wr_fire && w_lane_q && (aw_addr_q == CONTROL_OFS);
  assign wr_val = ctrl_t'(w_data_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_lane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_lane_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- bus slave: read path ----------------
  assign s_axi_arready = !s_axi_rvalid;
  assign stat = '{start_seen_flag: start_q, count_wrap_flag: wrap_q, stop_seen_flag: stop_q,
                  drive_mismatch_bit: data_q[7] ^ sda_s, bit_counter_value: cnt_q};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        DATA_OFS: s_axi_rdata <= {24'h000000, data_q};
        STATUS_OFS: s_axi_rdata <= {24'h000000, stat};
        // both strobe positions always read back as zero
        CONTROL_OFS: s_axi_rdata <= {24'h000000, ctrl_q[7:2], 2'h0};
        default: s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- control register ----------------
  // the strobe bit is kept only as the counter-source select under external clocking
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= ctrl_t'(CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_q <= wr_val;
      ctrl_q.soft_clock_strobe <= wr_val.clock_source_select[1] & wr_val.soft_clock_strobe;
      ctrl_q.clock_pin_toggle <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      clk_port_q <= 1'b0;
    end else if (wr_ctrl && wr_val.clock_pin_toggle) begin
      clk_port_q <= !clk_port_q;
    end
  end

  // ---------------- clock selection ----------------
  // strobes use the value being written so that mode and strobe may go in one write
  always_comb begin
    shift_tick = 1'b0;
    count_tick = 1'b0;
    unique case (ctrl_q.clock_source_select)
      CS_SOFT: ;
      CS_TIMER: begin
        shift_tick = timer0_overflow;
        count_tick = timer0_overflow;
      end
      CS_EXT_POS: begin
        shift_tick = pin_rise[1];
        count_tick = !ctrl_q.soft_clock_strobe && scl_edge;
      end
      CS_EXT_NEG: begin
        shift_tick = pin_fall[1];
        count_tick = !ctrl_q.soft_clock_strobe && scl_edge;
      end
    endcase
    if (wr_ctrl && wr_val.clock_source_select == CS_SOFT && wr_val.soft_clock_strobe) begin
      shift_tick = 1'b1;
      count_tick = 1'b1;
    end
    if (wr_ctrl && wr_val.clock_source_select[1] && wr_val.soft_clock_strobe &&
        wr_val.clock_pin_toggle) begin
      count_tick = 1'b1;
    end
  end

  // ---------------- shift register ----------------
  always_comb begin
    data_d = data_q;
    if (wr_data) begin
      data_d = w_data_q;
    end else if (shift_tick) begin
      data_d = {data_q[6:0], sda_s};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_q <= DATA_RESET;
    end else begin
      data_q <= data_d;
    end
  end

  // latch opens in the half-cycle before the sampling edge so output and sampling never collide
  assign latch_open = !ctrl_q.clock_source_select[1] ||
                      (scl_s == ctrl_q.clock_source_select[0]);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_latch_q <= 1'b0;
    end else if (latch_open) begin
      out_latch_q <= data_d[7];
    end
  end

  // ---------------- counter and flags ----------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= CNT_RESET;
    end else if (wr_stat) begin
      cnt_q <= w_data_q[CNT_W-1:0];
    end else if (count_tick) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // a clear in the same cycle as a set wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrap_q <= 1'b0;
    end else if (count_tick && !wr_stat && cnt_q == CNT_MAX) begin
      wrap_q <= 1'b1;
    end else if (wr_stat && w_data_q[STAT_WRAP_BIT]) begin
      wrap_q <= 1'b0;
    end
  end

  assign two_wire = ctrl_q.wire_mode_select[1];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      start_q <= 1'b0;
    end else if ((two_wire && scl_s && pin_fall[0]) ||
                 (!two_wire && ctrl_q.clock_source_select[1] &&
                  !ctrl_q.soft_clock_strobe && scl_edge)) begin
      start_q <= 1'b1;
    end else if (wr_stat && w_data_q[STAT_START_BIT]) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stop_q <= 1'b0;
    end else if (two_wire && scl_s && pin_rise[0]) begin
      stop_q <= 1'b1;
    end else if (wr_stat && w_data_q[STAT_STOP_BIT]) begin
      stop_q <= 1'b0;
    end
  end

  // start hold begins at the first falling clock after the start condition
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_armed_q <= 1'b0;
    end else if (!start_q || !two_wire) begin
      hold_armed_q <= 1'b0;
    end else if (pin_fall[1]) begin
      hold_armed_q <= 1'b1;
    end
  end

  // ---------------- pins ----------------
  assign scl_hold = two_wire && (hold_armed_q ||
                    (ctrl_q.wire_mode_select == WM_TWO_HOLD && wrap_q));
  assign data_out_o = out_latch_q;
  assign data_out_oe_n = !(ctrl_q.wire_mode_select == WM_THREE && data_pin_dir);
  assign sda_o = 1'b0;
  assign sda_oe_n = !(two_wire && data_pin_dir && (!out_latch_q || !data_port_bit));
  // open drain in two-wire modes; ordinary push-pull port pin otherwise
  assign scl_o = two_wire ? 1'b0 : clk_port_q;
  assign scl_oe_n = two_wire ? !(clock_pin_dir && (!clk_port_q || scl_hold)) : !clock_pin_dir;

  // ---------------- interrupts and wake ----------------
  assign start_irq = start_q && ctrl_q.start_irq_enable && global_irq_enable;
  assign wrap_irq = wrap_q && ctrl_q.wrap_irq_enable && global_irq_enable;
  // raw-pin term lets a start wake the core even with the clock stopped
  assign wake_any_sleep = start_irq || (two_wire && ctrl_q.start_irq_enable &&
                          serial_clock_pin && !serial_in_pin);
  assign wake_idle_sleep = wrap_irq && sleep_is_idle;

  // ---------------- checks ----------------
  sequence wrap_cause_s;
    count_tick && !wr_stat && cnt_q == CNT_MAX;
  endsequence

  sequence wrap_clear_s;
    wr_stat && w_data_q[STAT_WRAP_BIT] && !(count_tick && cnt_q == CNT_MAX);
  endsequence

  wrap_flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
    wrap_cause_s |=> wrap_q && cnt_q == 4'h0)
    else $error("wrap flag or counter wrong after count from fifteen");

  wrap_flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    wrap_clear_s |=> !wrap_q)
    else $error("wrap flag not cleared by write of one");

  write_beats_shift_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_data |=> data_q == $past(w_data_q))
    else $error("shift register lost the written value");

  shift_left_a: assert property (@(posedge clk) disable iff (!nrst)
    shift_tick && !wr_data |=> data_q == {$past(data_q[6:0]), $past(sda_s)})
    else $error("shift register did not shift left");

  latch_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    latch_open && !wr_data && !shift_tick |=> data_out_o == data_q[7])
    else $error("open latch does not show top bit");

  start_flag_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    start_q && !(wr_stat && w_data_q[STAT_START_BIT]) |=> start_q)
    else $error("start flag dropped without a clear");

  start_irq_out_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(start_q) && ctrl_q.start_irq_enable && global_irq_enable |-> start_irq)
    else $error("start interrupt missing");

  wrap_hold_scl_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_q.wire_mode_select == WM_TWO_HOLD && wrap_q && clock_pin_dir |-> !scl_oe_n)
    else $error("clock line not held after wrap");

  toggle_port_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_ctrl && wr_val.clock_pin_toggle |=> clk_port_q != $past(clk_port_q))
    else $error("toggle strobe did not invert clock port");

  strobe_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CONTROL_OFS |=> s_axi_rdata[1:0] == 2'h0)
    else $error("strobe bits read back nonzero");

  mode_off_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_q.wire_mode_select == WM_OFF |-> data_out_oe_n && sda_oe_n && !scl_hold)
    else $error("outputs active with wire mode off");

endmodule : serial_shift_unit

// >>> tb/serial_peer.sv
`timescale 1ns/100ps
// far-side bus partner: clock and data stand still outside frames
module serial_peer (
  input wire logic [1:0] op,
  input wire logic go,
  input wire logic [7:0] tx,
  output logic sck,
  output logic sda,
  output logic busy
);
  initial begin
    sck = 1'b0;
    sda = 1'b1;
    busy = 1'b0;
  end

  // op 1 = start condition, 2 = stop condition, else one byte msb first
  always @(posedge go) begin
    busy = 1'b1;
    #37;
    case (op)
      2'd1: begin
        sda = 1'b1;
        #200 sck = 1'b1;
        #200 sda = 1'b0;
        #200 sck = 1'b0;
      end
      2'd2: begin
        sda = 1'b0;
        #200 sck = 1'b1;
        #200 sda = 1'b1;
      end
      default: begin
        for (int i = 7; i >= 0; i--) begin
          sda = tx[i];
          #200 sck = 1'b1;
          #200 sck = 1'b0;
        end
        // frame over: data goes back to the pull-up level
        #200 sda = 1'b1;
      end
    endcase
    #200 busy = 1'b0;
  end
endmodule : serial_peer

// >>> tb/universal_serial_shift_unit_tb.sv
`timescale 1ns/100ps
module universal_serial_shift_unit_tb;
  import serial_shift_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic tmr = 1'b0, gie = 1'b0, idle = 1'b0, ddir = 1'b0, cdir = 1'b0;
  logic start_irq, wrap_irq, wake_any, wake_idle;
  logic do_o, do_oe_n, sda_o, sda_oe_n, scl_o, scl_oe_n;
  logic [1:0] pop = 2'd0;
  logic pgo = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic [7:0] rd;
  logic psck, psda, pbusy, sda_w, scl_w;
  int errors = 0;
  int compares = 0;

  // open-drain lines with pull-ups
  assign sda_w = psda & (sda_oe_n | sda_o);
  assign scl_w = psck & (scl_oe_n | scl_o);
  always #25 clk = ~clk;

  serial_peer i_peer (.op(pop), .go(pgo), .tx(ptx), .sck(psck), .sda(psda), .busy(pbusy));

  serial_shift_unit i_dut (
    .clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer0_overflow(tmr), .global_irq_enable(gie), .sleep_is_idle(idle),
    .data_pin_dir(ddir), .clock_pin_dir(cdir), .data_port_bit(1'b1),
    .start_irq(start_irq), .wrap_irq(wrap_irq), .wake_any_sleep(wake_any),
    .wake_idle_sleep(wake_idle), .serial_in_pin(sda_w), .serial_clock_pin(scl_w),
    .data_out_o(do_o), .data_out_oe_n(do_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n)
  );

  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      wrap_up();
    end
  endtask : tmo

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    tmo(n, 40);
  endtask : wr

  task automatic rdr(input logic [ADDR_W-1:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
    tmo(n, 40);
  endtask : rdr

  task automatic rc(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    rdr(a);
    chk(nm, e, rd & m);
  endtask : rc

  // let the pin logic and output latch catch up before looking
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic peer(input logic [1:0] o, input logic [7:0] t);
    int n;
    @(posedge clk);
    pop <= o;
    ptx <= t;
    pgo <= 1'b1;
    @(posedge clk);
    pgo <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (!pbusy) break;
    end
    tmo(n, 200);
    repeat (4) @(posedge clk);
  endtask : peer

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rc("data rst", DATA_OFS, 8'hff, DATA_RESET);
    rc("status rst", STATUS_OFS, 8'hef, 8'h00);
    rc("ctrl rst", CONTROL_OFS, 8'hff, CTRL_RESET);
    rdr(4'hc);
    chk("unmapped rresp", {6'h00, RESP_SLVERR}, {6'h00, rsp});
    wr(4'hc, 8'hff);
    chk("unmapped bresp", {6'h00, RESP_SLVERR}, {6'h00, rsp});
    // soft strobe from a preset of fifteen wraps the counter
    wr(DATA_OFS, 8'h81);
    wr(STATUS_OFS, 8'h0f);
    wr(CONTROL_OFS, 8'h42);
    rc("strobe shift", DATA_OFS, 8'hfe, 8'h02);
    rc("strobe reads 0", CONTROL_OFS, 8'hff, 8'h40);
    rc("wrap set", STATUS_OFS, 8'hef, 8'h40);
    gie <= 1'b1;
    idle <= 1'b1;
    settle();
    chk("wrap irq", 8'h01, {7'h00, wrap_irq});
    chk("wake idle", 8'h01, {7'h00, wake_idle});
    chk("wake any", 8'h00, {7'h00, wake_any});
    @(posedge clk);
    gie <= 1'b0;
    settle();
    chk("wrap irq masked", 8'h00, {7'h00, wrap_irq});
    wr(STATUS_OFS, 8'h40);
    rc("wrap clear", STATUS_OFS, 8'hef, 8'h00);
    // timer overflow as clock source
    wr(DATA_OFS, 8'h01);
    wr(CONTROL_OFS, 8'h04);
    repeat (3) begin
      @(posedge clk);
      tmr <= 1'b1;
      @(posedge clk);
      tmr <= 1'b0;
    end
    rc("timer shift", DATA_OFS, 8'hf8, 8'h08);
    rc("timer count", STATUS_OFS, 8'h0f, 8'h03);
    // external clock with outputs off: shift on rise, count both edges
    wr(STATUS_OFS, 8'he0);
    wr(CONTROL_OFS, 8'h08);
    peer(2'd0, 8'ha5);
    rc("ext data", DATA_OFS, 8'hff, 8'ha5);
    rc("ext status", STATUS_OFS, 8'hef, 8'hc0);
    // toggle strobe clocks the counter and the clock port
    wr(STATUS_OFS, 8'he0);
    wr(CONTROL_OFS, 8'h0b);
    rc("toggle count", STATUS_OFS, 8'h0f, 8'h01);
    rc("toggle reads 0", CONTROL_OFS, 8'hff, 8'h08);
    chk("clock port", 8'h01, {7'h00, scl_o});
    // three-wire output follows the top bit through the open latch
    ddir <= 1'b1;
    wr(CONTROL_OFS, 8'h10);
    wr(DATA_OFS, 8'h80);
    settle();
    chk("do high", 8'h01, {7'h00, do_o});
    chk("do enabled", 8'h00, {7'h00, do_oe_n});
    rc("no mismatch", STATUS_OFS, 8'h10, 8'h00);
    wr(DATA_OFS, 8'h00);
    settle();
    chk("do low", 8'h00, {7'h00, do_o});
    rc("mismatch", STATUS_OFS, 8'h10, 8'h10);
    wr(CONTROL_OFS, 8'h00);
    ddir <= 1'b0;
    settle();
    chk("do off", 8'h01, {7'h00, do_oe_n});
    // two-wire start, clock hold, release and stop
    @(posedge clk);
    cdir <= 1'b1;
    gie <= 1'b1;
    wr(STATUS_OFS, 8'he0);
    wr(CONTROL_OFS, 8'ha0);
    peer(2'd1, 8'h00);
    rc("start flag", STATUS_OFS, 8'he0, 8'h80);
    chk("start irq", 8'h01, {7'h00, start_irq});
    chk("scl held", 8'h00, {7'h00, scl_oe_n});
    wr(STATUS_OFS, 8'h80);
    settle();
    chk("scl freed", 8'h01, {7'h00, scl_oe_n});
    chk("start irq off", 8'h00, {7'h00, start_irq});
    peer(2'd2, 8'h00);
    rc("stop flag", STATUS_OFS, 8'he0, 8'h20);
    chk("stop no irq", 8'h00, {7'h00, start_irq});
    // mode three: a wrap also holds the clock line until the flag is cleared
    wr(STATUS_OFS, 8'h0f);
    wr(CONTROL_OFS, 8'h32);
    settle();
    chk("wrap holds scl", 8'h00, {7'h00, scl_oe_n});
    wr(STATUS_OFS, 8'h40);
    settle();
    chk("wrap frees scl", 8'h01, {7'h00, scl_oe_n});
    // two-wire data output pulls the line low from a zero top bit
    ddir <= 1'b1;
    wr(DATA_OFS, 8'h00);
    settle();
    chk("sda pulled", 8'h00, {7'h00, sda_oe_n});
    rc("no collision", STATUS_OFS, 8'h10, 8'h00);
    wrap_up();
  end
endmodule : universal_serial_shift_unit_tb
